// [pkg/gcc_defines.svh]
// register map, field positions, reset values and counts of the gamma core control layer
`ifndef GCC_DEFINES_SVH
`define GCC_DEFINES_SVH

`define GCC_OFF_CONTROL 9'h000
`define GCC_OFF_STATUS 9'h004
`define GCC_OFF_ERROR 9'h008
`define GCC_OFF_IRQ_MASK 9'h00c
`define GCC_OFF_VERSION 9'h010
`define GCC_OFF_FRAME_CNT 9'h014
`define GCC_OFF_LINE_CNT 9'h018
`define GCC_OFF_PIXEL_CNT 9'h01c
`define GCC_OFF_DIMS 9'h020
`define GCC_OFF_LUT_UPD 9'h100
`define GCC_OFF_LUT_PORT 9'h104

`define GCC_CTRL_ENABLE_BIT 0
`define GCC_CTRL_COMMIT_BIT 1
`define GCC_CTRL_IMM_RST_BIT 30
`define GCC_CTRL_SYNC_RST_BIT 31

`define GCC_STAT_BUSY_BIT 0
`define GCC_STAT_RST_BIT 1
`define GCC_STAT_SYNCED_BIT 2
`define GCC_STAT_PEND_BIT 3

`define GCC_ERR_SOF_EARLY_BIT 0

`define GCC_DIMS_ROWS_LSB 16
`define GCC_DIMS_ROWS_MSB 28

`define GCC_CTRL_ENABLE_RST 1'h0
`define GCC_CTRL_COMMIT_RST 1'h1
`define GCC_WORD_RST 32'h0000_0000
`define GCC_DIMS_RST 32'h0000_0000

`define GCC_RESP_OKAY 2'h0
`define GCC_SYNC_RST_CYCLES 32

`endif

// [pkg/gcc_pkg.sv]
// types shared by the gamma core control modules
package gcc_pkg;
  typedef enum logic [2:0] {
    GCC_SEQ_IDLE  = 3'b001,
    GCC_SEQ_WAIT  = 3'b010,
    GCC_SEQ_PULSE = 3'b100
  } gcc_seq_state_t;
endpackage : gcc_pkg

// [pkg/gcc_rst_if.sv]
// reset sequencing signals between the register layer and the reset sequencer
`timescale 1ns/1ps
interface gcc_rst_if;
  logic imm_flag;
  logic sync_req;
  logic frame_busy;
  logic frame_edge;
  logic core_rst;
  logic sync_pending;
  gcc_pkg::gcc_seq_state_t state;
  modport ctrl (output imm_flag, output sync_req, output frame_busy, output frame_edge,
                input core_rst, input sync_pending, input state);
  modport seq (input imm_flag, input sync_req, input frame_busy, input frame_edge,
               output core_rst, output sync_pending, output state);
endinterface : gcc_rst_if

// [core/gcc_reset_seq.sv]
// immediate and frame-synchronised reset sequencer
`timescale 1ns/1ps
`include "gcc_defines.svh"
module gcc_reset_seq #(
  parameter int PULSE_CYCLES = `GCC_SYNC_RST_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // sequencing
  gcc_rst_if.seq rst_if
);
  import gcc_pkg::*;
  localparam int CW = $clog2(PULSE_CYCLES + 1);

  gcc_seq_state_t state_reg;
  gcc_seq_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic core_rst_reg;
  logic [7:0] len_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      GCC_SEQ_IDLE: begin
        if (rst_if.sync_req) begin
          state_next = rst_if.frame_busy ? GCC_SEQ_WAIT : GCC_SEQ_PULSE;
        end
      end
      GCC_SEQ_WAIT: begin
        // a stalled stream gives no edge, so the request just waits
        if (rst_if.frame_edge) begin
          state_next = GCC_SEQ_PULSE;
        end
      end
      GCC_SEQ_PULSE: begin
        if (cnt_reg == CW'(PULSE_CYCLES - 1)) begin
          state_next = GCC_SEQ_IDLE;
        end
      end
    endcase
    // the immediate reset covers any pending sequence
    if (rst_if.imm_flag) begin
      state_next = GCC_SEQ_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= GCC_SEQ_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next == GCC_SEQ_PULSE && state_reg == GCC_SEQ_PULSE) ?
                 cnt_reg + CW'(1) : '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_rst_reg <= 1'b0;
    end else begin
      core_rst_reg <= rst_if.imm_flag || state_next == GCC_SEQ_PULSE;
    end
  end

  assign rst_if.core_rst = core_rst_reg;
  assign rst_if.sync_pending = state_reg != GCC_SEQ_IDLE;
  assign rst_if.state = state_reg;

  // length of the current pulse, read only by the checks
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      len_reg <= '0;
    end else begin
      len_reg <= (state_reg == GCC_SEQ_PULSE) ? len_reg + 8'h01 : 8'h00;
    end
  end

  pulse_length_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $fell(state_reg == GCC_SEQ_PULSE) && !$past(rst_if.imm_flag) |-> len_reg == 8'(PULSE_CYCLES))
    else $error("frame-synchronised reset pulse has wrong length");
  idle_start_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state_reg == GCC_SEQ_IDLE && rst_if.sync_req && !rst_if.frame_busy && !rst_if.imm_flag
    |=> state_reg == GCC_SEQ_PULSE && core_rst_reg)
    else $error("idle reset request did not start at once");
  wait_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state_reg == GCC_SEQ_WAIT && !rst_if.frame_edge && !rst_if.imm_flag |=> state_reg == GCC_SEQ_WAIT)
    else $error("deferred reset left wait without frame edge");
  pulse_seen_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state_reg == GCC_SEQ_WAIT ##[1:200] state_reg == GCC_SEQ_PULSE);
endmodule : gcc_reset_seq

// [core/gcc_core_control.sv]
// axi4-lite register layer, double buffering and stream gating of the gamma core
`timescale 1ns/1ps
`include "gcc_defines.svh"
module gcc_core_control #(
  parameter int DATA_W = 24,
  parameter int ADDR_W = 9,
  parameter logic [31:0] VERSION_CODE = 32'h0001_0000  // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // input video stream
  input wire logic [DATA_W-1:0] in_stream_tdata_i,
  input wire logic in_stream_tvalid_i,
  input wire logic in_stream_frame_start_i,
  input wire logic in_stream_tlast_i,
  output logic in_stream_ready_o,
  // output video stream
  output logic [DATA_W-1:0] out_stream_tdata_o,
  output logic out_stream_valid_o,
  output logic out_stream_frame_start_o,
  output logic out_stream_tlast_o,
  input wire logic out_stream_tready_i,
  // working values for the datapath
  output logic [31:0] active_dims_o,
  output logic [31:0] active_lut_update_o,
  output logic [31:0] lut_write_data_o,
  output logic lut_write_stb_o,
  output logic core_in_reset_o,
  output gcc_pkg::gcc_seq_state_t reset_state_o
);
  import gcc_pkg::*;

  function automatic logic [31:0] gcc_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : gcc_merge

  gcc_rst_if rst_if ();

  logic core_rst;
  logic awready_reg;
  logic bvalid_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_fire;
  logic rd_fire;
  logic ctrl_enable_reg;
  logic ctrl_commit_reg;
  logic ctrl_imm_reg;
  logic sync_req_reg;
  logic [31:0] err_reg;
  logic [31:0] irq_mask_reg;
  logic [31:0] dims_shadow_reg;
  logic [31:0] dims_work_reg;
  logic [31:0] lut_shadow_reg;
  logic [31:0] lut_work_reg;
  logic [31:0] lut_port_reg;
  logic lut_stb_reg;
  logic [31:0] frame_cnt_reg;
  logic [31:0] line_cnt_reg;
  logic [31:0] pixel_cnt_reg;
  logic in_ready_reg;
  logic out_valid_reg;
  logic [DATA_W-1:0] out_data_reg;
  logic out_sof_reg;
  logic out_last_reg;
  logic synced_reg;
  logic busy_reg;
  logic [12:0] line_idx_reg;
  logic [12:0] cur_line;
  logic [12:0] rows;
  logic in_fire;
  logic out_fire;
  logic keep;
  logic sof_keep;
  logic eol_keep;
  logic frame_end;
  logic [31:0] ctrl_word;

  assign core_rst = rst_if.core_rst;

  // axi4-lite handshakes; address and data are taken together
  assign wr_fire = s_axi_awvalid_i && s_axi_wvalid_i && !awready_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid_i && !arready_reg && !rvalid_reg;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      awready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
    end else begin
      awready_reg <= wr_fire;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
      end else if (s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= `GCC_WORD_RST;
    end else begin
      arready_reg <= rd_fire;
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rdata_next;
      end else if (s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign ctrl_word = {sync_req_reg || rst_if.sync_pending, ctrl_imm_reg, 28'h000_0000,
                      ctrl_commit_reg, ctrl_enable_reg};

  always_comb begin
    rdata_next = `GCC_WORD_RST;
    unique case (s_axi_araddr_i)
      `GCC_OFF_CONTROL: rdata_next = ctrl_word;
      `GCC_OFF_STATUS: begin
        rdata_next[`GCC_STAT_BUSY_BIT] = busy_reg;
        rdata_next[`GCC_STAT_RST_BIT] = core_rst;
        rdata_next[`GCC_STAT_SYNCED_BIT] = synced_reg;
        rdata_next[`GCC_STAT_PEND_BIT] = rst_if.sync_pending;
      end
      `GCC_OFF_ERROR: rdata_next = err_reg;
      `GCC_OFF_IRQ_MASK: rdata_next = irq_mask_reg;
      `GCC_OFF_VERSION: rdata_next = VERSION_CODE;
      `GCC_OFF_FRAME_CNT: rdata_next = frame_cnt_reg;
      `GCC_OFF_LINE_CNT: rdata_next = line_cnt_reg;
      `GCC_OFF_PIXEL_CNT: rdata_next = pixel_cnt_reg;
      `GCC_OFF_DIMS: rdata_next = dims_shadow_reg;
      `GCC_OFF_LUT_UPD: rdata_next = lut_shadow_reg;
      `GCC_OFF_LUT_PORT: rdata_next = lut_port_reg;
      default: rdata_next = `GCC_WORD_RST;
    endcase
  end

  // control register; the reset flag itself survives the core reset it causes
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_enable_reg <= `GCC_CTRL_ENABLE_RST;
      ctrl_commit_reg <= `GCC_CTRL_COMMIT_RST;
      ctrl_imm_reg <= 1'b0;
      sync_req_reg <= 1'b0;
    end else begin
      sync_req_reg <= 1'b0;
      if (core_rst) begin
        ctrl_enable_reg <= `GCC_CTRL_ENABLE_RST;
        ctrl_commit_reg <= `GCC_CTRL_COMMIT_RST;
      end
      if (wr_fire && s_axi_awaddr_i == `GCC_OFF_CONTROL) begin
        if (s_axi_wstrb_i[3]) begin
          ctrl_imm_reg <= s_axi_wdata_i[`GCC_CTRL_IMM_RST_BIT];
        end
        if (!core_rst && s_axi_wstrb_i[0]) begin
          ctrl_enable_reg <= s_axi_wdata_i[`GCC_CTRL_ENABLE_BIT];
          ctrl_commit_reg <= s_axi_wdata_i[`GCC_CTRL_COMMIT_BIT];
        end
        if (!core_rst && s_axi_wstrb_i[3]) begin
          sync_req_reg <= s_axi_wdata_i[`GCC_CTRL_SYNC_RST_BIT];
        end
      end
    end
  end

  // other host registers; writes during core reset are dropped
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_mask_reg <= `GCC_WORD_RST;
      dims_shadow_reg <= `GCC_DIMS_RST;
      lut_shadow_reg <= `GCC_WORD_RST;
      lut_port_reg <= `GCC_WORD_RST;
      lut_stb_reg <= 1'b0;
    end else if (core_rst) begin
      irq_mask_reg <= `GCC_WORD_RST;
      dims_shadow_reg <= `GCC_DIMS_RST;
      lut_shadow_reg <= `GCC_WORD_RST;
      lut_port_reg <= `GCC_WORD_RST;
      lut_stb_reg <= 1'b0;
    end else begin
      lut_stb_reg <= wr_fire && s_axi_awaddr_i == `GCC_OFF_LUT_PORT;
      if (wr_fire) begin
        unique case (s_axi_awaddr_i)
          `GCC_OFF_IRQ_MASK: irq_mask_reg <= gcc_merge(irq_mask_reg, s_axi_wdata_i, s_axi_wstrb_i);
          `GCC_OFF_DIMS: dims_shadow_reg <= gcc_merge(dims_shadow_reg, s_axi_wdata_i,
                                                      s_axi_wstrb_i);
          `GCC_OFF_LUT_UPD: lut_shadow_reg <= gcc_merge(lut_shadow_reg, s_axi_wdata_i,
                                                        s_axi_wstrb_i);
          `GCC_OFF_LUT_PORT: lut_port_reg <= gcc_merge(lut_port_reg, s_axi_wdata_i, s_axi_wstrb_i);
          default: lut_port_reg <= lut_port_reg;
        endcase
      end
    end
  end

  // sticky early frame start flag, write one to clear, a new event wins
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_reg <= `GCC_WORD_RST;
    end else if (core_rst) begin
      err_reg <= `GCC_WORD_RST;
    end else begin
      if (wr_fire && s_axi_awaddr_i == `GCC_OFF_ERROR && s_axi_wstrb_i[0] &&
          s_axi_wdata_i[`GCC_ERR_SOF_EARLY_BIT]) begin
        err_reg[`GCC_ERR_SOF_EARLY_BIT] <= 1'b0;
      end
      if (sof_keep && busy_reg) begin
        err_reg[`GCC_ERR_SOF_EARLY_BIT] <= 1'b1;
      end
    end
  end

  // stream gating; one output stage keeps every output on a flop at half rate
  assign in_fire = in_stream_tvalid_i && in_ready_reg;
  assign out_fire = out_valid_reg && out_stream_tready_i;
  assign keep = in_fire && (synced_reg || in_stream_frame_start_i);
  assign sof_keep = keep && in_stream_frame_start_i;
  assign eol_keep = keep && in_stream_tlast_i;
  assign cur_line = in_stream_frame_start_i ? 13'h0000 : line_idx_reg;
  assign rows = dims_work_reg[`GCC_DIMS_ROWS_MSB:`GCC_DIMS_ROWS_LSB];
  assign frame_end = eol_keep && (cur_line == rows - 13'h0001);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
      out_sof_reg <= 1'b0;
      out_last_reg <= 1'b0;
    end else if (core_rst) begin
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      in_ready_reg <= ctrl_enable_reg && !keep && !(out_valid_reg && !out_fire);
      if (keep) begin
        out_valid_reg <= 1'b1;
        out_data_reg <= in_stream_tdata_i;
        out_sof_reg <= in_stream_frame_start_i;
        out_last_reg <= in_stream_tlast_i;
      end else if (out_fire) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  // frame tracking for resync and the frame-synchronised reset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      synced_reg <= 1'b0;
      busy_reg <= 1'b0;
      line_idx_reg <= '0;
    end else if (core_rst || !ctrl_enable_reg) begin
      synced_reg <= 1'b0;
      busy_reg <= 1'b0;
      line_idx_reg <= '0;
    end else begin
      if (sof_keep) begin
        synced_reg <= 1'b1;
      end
      if (frame_end) begin
        busy_reg <= 1'b0;
        line_idx_reg <= '0;
      end else begin
        if (sof_keep) begin
          busy_reg <= 1'b1;
        end
        if (eol_keep) begin
          line_idx_reg <= cur_line + 13'h0001;
        end else if (sof_keep) begin
          line_idx_reg <= '0;
        end
      end
    end
  end

  // working copies follow the shadows only at an accepted frame start
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dims_work_reg <= `GCC_DIMS_RST;
      lut_work_reg <= `GCC_WORD_RST;
    end else if (core_rst) begin
      dims_work_reg <= `GCC_DIMS_RST;
      lut_work_reg <= `GCC_WORD_RST;
    end else if (sof_keep && ctrl_commit_reg) begin
      dims_work_reg <= dims_shadow_reg;
      lut_work_reg <= lut_shadow_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_cnt_reg <= `GCC_WORD_RST;
      line_cnt_reg <= `GCC_WORD_RST;
      pixel_cnt_reg <= `GCC_WORD_RST;
    end else if (core_rst) begin
      frame_cnt_reg <= `GCC_WORD_RST;
      line_cnt_reg <= `GCC_WORD_RST;
      pixel_cnt_reg <= `GCC_WORD_RST;
    end else begin
      frame_cnt_reg <= frame_cnt_reg + {31'h0000_0000, frame_end};
      line_cnt_reg <= line_cnt_reg + {31'h0000_0000, eol_keep};
      pixel_cnt_reg <= pixel_cnt_reg + {31'h0000_0000, keep};
    end
  end

  assign rst_if.imm_flag = ctrl_imm_reg;
  assign rst_if.sync_req = sync_req_reg;
  assign rst_if.frame_busy = busy_reg;
  assign rst_if.frame_edge = frame_end || sof_keep;

  gcc_reset_seq #(
    .PULSE_CYCLES(`GCC_SYNC_RST_CYCLES)
  ) u_reset_seq (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .rst_if(rst_if.seq)
  );

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = awready_reg;
  assign s_axi_bresp_o = `GCC_RESP_OKAY;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = `GCC_RESP_OKAY;
  assign s_axi_rvalid_o = rvalid_reg;
  assign in_stream_ready_o = in_ready_reg;
  assign out_stream_tdata_o = out_data_reg;
  assign out_stream_valid_o = out_valid_reg;
  assign out_stream_frame_start_o = out_sof_reg;
  assign out_stream_tlast_o = out_last_reg;
  assign active_dims_o = dims_work_reg;
  assign active_lut_update_o = lut_work_reg;
  assign lut_write_data_o = lut_port_reg;
  assign lut_write_stb_o = lut_stb_reg;
  assign core_in_reset_o = core_rst;
  assign reset_state_o = rst_if.state;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  rst_drops_stream_a: assert property (core_rst |=> !in_ready_reg && !out_valid_reg)
    else $error("stream handshake active during core reset");
  imm_reset_a: assert property (wr_fire && s_axi_awaddr_i == `GCC_OFF_CONTROL &&
    s_axi_wstrb_i[3] && s_axi_wdata_i[`GCC_CTRL_IMM_RST_BIT] |-> ##2 core_rst)
    else $error("immediate reset did not take effect");
  held_in_reset_a: assert property (ctrl_imm_reg |=> core_rst)
    else $error("core left reset while flag set");
  resync_wait_a: assert property (in_fire && !synced_reg && !in_stream_frame_start_i
    |=> !out_valid_reg)
    else $error("pixel forwarded before frame start");
  commit_load_a: assert property (sof_keep && ctrl_commit_reg && !core_rst
    |=> dims_work_reg == $past(dims_shadow_reg) && lut_work_reg == $past(lut_shadow_reg))
    else $error("working copy not loaded at frame start");
  commit_hold_a: assert property (!ctrl_commit_reg && !core_rst
    |=> $stable(dims_work_reg) && $stable(lut_work_reg))
    else $error("working copy changed with commit flag clear");
  disable_stops_a: assert property (!ctrl_enable_reg ##1 !ctrl_enable_reg |-> !in_ready_reg)
    else $error("stream accepted while disabled");
  counters_zero_a: assert property ($fell(core_rst) |-> frame_cnt_reg == 32'h0000_0000 &&
    line_cnt_reg == 32'h0000_0000 && pixel_cnt_reg == 32'h0000_0000)
    else $error("counters not cleared by core reset");
  unmapped_read_a: assert property (rd_fire && s_axi_araddr_i > `GCC_OFF_LUT_PORT
    |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h0000_0000 && s_axi_rresp_o == `GCC_RESP_OKAY)
    else $error("unmapped read not answered with zero");
  write_answer_a: assert property (wr_fire |=> s_axi_bvalid_o ##0 s_axi_awready_o)
    else $error("write not answered next cycle");

  frame_done_c: cover property (frame_end ##[1:100] sof_keep);
  commit_c: cover property (sof_keep && ctrl_commit_reg);
  imm_release_c: cover property ($fell(ctrl_imm_reg) ##[1:200] sof_keep);
  backpressure_c: cover property (out_valid_reg && !out_stream_tready_i [*3]);
endmodule : gcc_core_control

// [verif/gcc_video_model.sv]
// behavioural video source and stalling sink around the core
`timescale 1ns/1ps
module gcc_video_model (
  // clock and control
  input wire logic sys_clk_i,
  input wire logic start_i,
  output logic busy_o,
  // stream into the core
  output logic [23:0] tdata_o,
  output logic tvalid_o,
  output logic sof_o,
  output logic tlast_o,
  input wire logic ready_i,
  // sink of the core output
  output logic tready_o
);
  int beat = 0;
  logic took, go;
  initial {busy_o, tvalid_o, sof_o, tlast_o, tready_o, tdata_o} = '0;
  // two lines of two beats; a beat is held until taken, a released bus shows junk
  always @(posedge sys_clk_i) begin
    took = tvalid_o && ready_i;
    go = start_i && !busy_o;
    #1;
    tready_o = !tready_o;
    if (took) beat++;
    if (go) begin
      busy_o = 1;
      beat = 0;
    end
    if (busy_o && beat == 4) begin
      {busy_o, tvalid_o, sof_o, tlast_o} = '0;
      tdata_o = ~tdata_o;
    end else if (busy_o) begin
      tvalid_o = 1;
      tdata_o = 24'h00_0100 + beat[23:0];
      sof_o = beat == 0;
      tlast_o = beat[0];
    end
  end
endmodule : gcc_video_model

// [verif/testbench.sv]
// self-checking bench of the gamma core control layer
`timescale 1ns/1ps
module testbench;
  logic sys_clk_i = 0, nrst_i = 0, awvalid = 0, wvalid = 0, arvalid = 0, start = 0;
  logic [8:0] awaddr = 9'h000, araddr = 9'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, dims, lupd, lwd, got;
  logic awready, wready, bvalid, arready, rvalid, tvalid, sof, tlast, iready;
  logic ovalid, osof, olast, otready, lstb, inrst, busy;
  logic [1:0] bresp, rresp;
  logic [23:0] tdata, odata;
  gcc_pkg::gcc_seq_state_t rstate;
  int bad_count = 0, samples_checked = 0, cyc = 0, run = 0, last = 0;
  initial forever #2.5 sys_clk_i = !sys_clk_i;
  gcc_core_control #(.VERSION_CODE(32'h0001_0000)) gcc_core_control_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'b1), .in_stream_tdata_i(tdata), .in_stream_tvalid_i(tvalid),
    .in_stream_frame_start_i(sof), .in_stream_tlast_i(tlast), .in_stream_ready_o(iready),
    .out_stream_tdata_o(odata), .out_stream_valid_o(ovalid),
    .out_stream_frame_start_o(osof), .out_stream_tlast_o(olast),
    .out_stream_tready_i(otready), .active_dims_o(dims), .active_lut_update_o(lupd),
    .lut_write_data_o(lwd), .lut_write_stb_o(lstb), .core_in_reset_o(inrst),
    .reset_state_o(rstate));
  gcc_video_model gcc_video_model_i (.sys_clk_i(sys_clk_i), .start_i(start), .busy_o(busy),
    .tdata_o(tdata), .tvalid_o(tvalid), .sof_o(sof), .tlast_o(tlast), .ready_i(iready),
    .tready_o(otready));
  // length of the last internal reset pulse
  always @(posedge sys_clk_i) begin
    if (inrst === 1'b1) run++;
    else if (run != 0) begin
      last = run;
      run = 0;
    end
    if (ovalid === 1'b1 && otready === 1'b1)
      chk({osof, olast, odata[23:2]}, {odata[1:0] == 2'h0, odata[0], 22'h00_0040});
    if (++cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    int n = 0;
    {awaddr, wdata, awvalid, wvalid} = {a, d, 2'b11};
    do @(posedge sys_clk_i); while (awready !== 1'b1 && ++n < 50);
    if (n == 50) bad_count++;
    chk({wready, bvalid, bresp}, 32'h0000_000c);
    #1 {awvalid, wvalid} = 2'b00;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : wr
  task automatic rchk(input logic [8:0] a, input logic [31:0] e);
    int n = 0;
    {araddr, arvalid} = {a, 1'b1};
    do @(posedge sys_clk_i); while (arready !== 1'b1 && ++n < 50);
    if (n == 50) bad_count++;
    got = rdata;
    chk({rvalid, rresp}, 32'h0000_0004);
    #1 arvalid = 0;
    repeat (2) @(posedge sys_clk_i);
    #1 chk(got, e);
  endtask : rchk
  task automatic frame();
    int n = 0;
    start = 1;
    @(posedge sys_clk_i);
    #1 start = 0;
    do @(posedge sys_clk_i); while (busy === 1'b1 && ++n < 200);
    if (n == 200) bad_count++;
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask : frame
  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1 nrst_i = 1;
    rchk(9'h000, 32'h0000_0002);
    rchk(9'h010, 32'h0001_0000);
    wr(9'h040, 32'hffff_ffff);
    rchk(9'h040, 32'h0000_0000);
    rchk(9'h1fc, 32'h0000_0000);
    wr(9'h104, 32'h0000_00a5);
    rchk(9'h104, 32'h0000_00a5);
    chk(lwd, 32'h0000_00a5);
    wr(9'h100, 32'h0000_0055);
    wr(9'h020, 32'h0002_0002);
    rchk(9'h020, 32'h0002_0002);
    chk(dims, 32'h0000_0000);
    wr(9'h000, 32'h0000_0003);
    frame();
    chk(dims, 32'h0002_0002);
    chk(lupd, 32'h0000_0055);
    rchk(9'h014, 32'h0000_0001);
    rchk(9'h018, 32'h0000_0002);
    rchk(9'h01c, 32'h0000_0004);
    wr(9'h000, 32'h0000_0001);
    wr(9'h020, 32'h0003_0002);
    frame();
    chk(dims, 32'h0002_0002);
    chk(lupd, 32'h0000_0055);
    wr(9'h000, 32'h0000_0000);
    chk({31'h0, iready}, 32'h0000_0000);
    wr(9'h000, 32'h8000_0003);
    repeat (40) @(posedge sys_clk_i);
    #1 chk(last, 32);
    rchk(9'h014, 32'h0000_0000);
    rchk(9'h020, 32'h0000_0000);
    wr(9'h000, 32'h4000_0003);
    chk({inrst, iready, ovalid}, 32'h0000_0004);
    repeat (40) @(posedge sys_clk_i);
    #1 chk({31'h0, inrst}, 32'h0000_0001);
    wr(9'h000, 32'h0000_0003);
    chk({31'h0, inrst}, 32'h0000_0000);
    wr(9'h020, 32'h0002_0002);
    wr(9'h000, 32'h0000_0003);
    start = 1;
    wr(9'h000, 32'h0000_0002);
    start = 0;
    wr(9'h000, 32'h0000_0003);
    repeat (20) @(posedge sys_clk_i);
    #1 rchk(9'h014, 32'h0000_0000);
    frame();
    rchk(9'h014, 32'h0000_0001);
    start = 1;
    repeat (3) @(posedge sys_clk_i);
    #1 start = 0;
    wr(9'h000, 32'h8000_0003);
    chk({29'h0, rstate}, 32'h0000_0002);
    repeat (60) @(posedge sys_clk_i);
    #1 chk(last, 32);
    wrap_up();
  end
endmodule : testbench
